// [inc/rsl_pkg.sv]
// shared constants, types and helpers of the reset source logic
package rsl_pkg;

    // ==========================================
    // timing
    localparam int unsigned SYSCLK_KHZ = 20000;
    localparam int unsigned LOSS_TIME_US = 100;
    localparam int unsigned LOSS_CYC = (LOSS_TIME_US * SYSCLK_KHZ) / 1000;
    localparam int unsigned POR_DELAY_US = 300;
    localparam int unsigned POR_DELAY_CYC = (POR_DELAY_US * SYSCLK_KHZ + 999) / 1000;
    localparam int unsigned CNT_W = 13;
    typedef logic [CNT_W-1:0] rsl_cnt_t;

    // ==========================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_SMC = 10'h0FF;
    localparam logic [9:0] IDX_RSS = 10'h0EF;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h0F0;
    localparam logic [9:0] IDX_IRQ_CLR = 10'h0F1;
    localparam logic [9:0] IDX_IRQ_EN = 10'h0F2;

    // ==========================================
    // field positions
    localparam int SMC_EN_BIT = 7;
    localparam int SMC_STAT_BIT = 6;
    localparam int RSS_PIN_BIT = 0;
    localparam int RSS_POR_BIT = 1;
    localparam int RSS_LOSS_BIT = 2;
    localparam int RSS_SW_BIT = 4;
    localparam int RSS_CMP_BIT = 5;
    localparam int IRQ_W = 3;
    localparam int IRQ_SUPPLY_BIT = 0;
    localparam int IRQ_CMP_BIT = 1;
    localparam int IRQ_LOSS_BIT = 2;

    // ==========================================
    // values after reset
    localparam logic MON_EN_RST = 1'b0;
    localparam logic SEL_RST = 1'b0;
    localparam logic [5:0] RSS_FLAGS_RST = 6'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // ==========================================
    // states and reset causes, causes listed from highest priority
    typedef enum logic [1:0] {ST_POR, ST_RUN, ST_HOLD} rsl_state_t;
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_SUPPLY, CAUSE_PIN, CAUSE_LOSS, CAUSE_CMP, CAUSE_SW
    } rsl_cause_t;

    function automatic logic word_hit(input logic [11:0] addr, input logic [9:0] idx);
        return (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

endpackage

// [logic/rsl_clock_loss.sv]
// repeating timeout detector for a clock that stops at one level, pulses again every hold count while stopped
`timescale 1ns/1ps
module rsl_clock_loss (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic enable_i,
    input wire logic mon_clk_i,
    output logic timeout_o
);

    rsl_pkg::rsl_cnt_t cnt;
    rsl_pkg::rsl_cnt_t next_cnt;
    logic last_lvl;
    logic next_last_lvl;
    logic next_timeout;

    // ==========================================
    // level hold counter
    always_comb
    begin
        next_last_lvl = mon_clk_i;
        next_timeout = 1'b0;
        next_cnt = cnt;
        if (!enable_i || (mon_clk_i != last_lvl))
        begin
            next_cnt = '0;
        end
        else if (cnt == rsl_pkg::rsl_cnt_t'(rsl_pkg::LOSS_CYC))
        begin
            next_cnt = '0;
            next_timeout = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt <= '0;
            last_lvl <= 1'b0;
            timeout_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt <= next_cnt;
            last_lvl <= next_last_lvl;
            timeout_o <= next_timeout;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    loss_enable_a: assert property ($rose(timeout_o) |-> $past(enable_i))
        else $error("clock loss timeout while detector disabled");
    loss_time_a: assert property ($rose(timeout_o)
        |-> $past(cnt) == rsl_pkg::rsl_cnt_t'(rsl_pkg::LOSS_CYC))
        else $error("clock loss timeout without hold count");

endmodule

// [logic/rsl_reset_source_logic.sv]
// reset source logic with apb registers
// ==========================================
// How it works
// - enabled, selected supply monitor low drives reset pin low and holds core reset
// - power-on reset forces the supply monitor enable off
// - other resets leave the supply monitor enable untouched
// - no power-on release delay after a supply monitor reset
// - supply level status bit mirrors monitor output live
// - low external reset pin resets the device
// - pin reset flag set after a pin caused reset
// - enabled detector resets when the watched clock holds one level 100 us
// - clock loss flag reads 1 only after clock loss reset
// - writing clock loss flag position enables or disables the detector
// - clock loss and comparator resets leave the reset pin alone
// - writing 1 at comparator flag position selects comparator as source
// - selected comparator holds reset while its output is low
// - comparator flag reads 1 only after comparator reset
// - power-on flag set after power-on and supply monitor resets, cleared by other resets
// - writing 1 to software reset flag forces reset, flag then reads 1
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module rsl_reset_source_logic #(
    parameter int unsigned POR_DELAY_CYC = rsl_pkg::POR_DELAY_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic supply_ok_i,
    input wire logic pin_rst_b_i,
    input wire logic cmp_out_i,
    input wire logic mon_clk_i,
    output logic sys_rst_b_o,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic irq_o
);

    rsl_pkg::rsl_state_t state;
    rsl_pkg::rsl_state_t next_state;
    rsl_pkg::rsl_cause_t cause;
    rsl_pkg::rsl_cause_t next_cause;
    rsl_pkg::rsl_cause_t hit_cause;
    rsl_pkg::rsl_cnt_t cnt;
    rsl_pkg::rsl_cnt_t next_cnt;
    logic [5:0] rss_flags;
    logic [5:0] next_rss_flags;
    logic next_sys_rst_b;
    logic next_pin_oe;
    logic mon_en;
    logic next_mon_en;
    logic sup_sel;
    logic next_sup_sel;
    logic loss_en;
    logic next_loss_en;
    logic cmp_sel;
    logic next_cmp_sel;
    logic [31:0] next_prdata;
    logic [rsl_pkg::IRQ_W-1:0] irq_stat;
    logic [rsl_pkg::IRQ_W-1:0] next_irq_stat;
    logic [rsl_pkg::IRQ_W-1:0] irq_en;
    logic [rsl_pkg::IRQ_W-1:0] next_irq_en;
    logic [rsl_pkg::IRQ_W-1:0] irq_ev;
    logic [rsl_pkg::IRQ_W-1:0] irq_clr;
    logic sup_prev;
    logic cmp_prev;
    logic loss_pulse;
    logic setup;
    logic access;
    logic mapped;
    logic wr_smc;
    logic wr_rss;
    logic wr_en;
    logic wr_clr;
    logic sw_hit;
    logic rd_armed;
    logic next_rd_armed;

    // flag word shown after a reset of the given cause
    function automatic logic [5:0] flag_word(input rsl_pkg::rsl_cause_t c);
        logic [5:0] f;
        f = 6'h00;
        unique case (c)
            rsl_pkg::CAUSE_SUPPLY: f[rsl_pkg::RSS_POR_BIT] = 1'b1;
            rsl_pkg::CAUSE_PIN: f[rsl_pkg::RSS_PIN_BIT] = 1'b1;
            rsl_pkg::CAUSE_LOSS: f[rsl_pkg::RSS_LOSS_BIT] = 1'b1;
            rsl_pkg::CAUSE_CMP: f[rsl_pkg::RSS_CMP_BIT] = 1'b1;
            rsl_pkg::CAUSE_SW: f[rsl_pkg::RSS_SW_BIT] = 1'b1;
            rsl_pkg::CAUSE_NONE: f = 6'h00;
            default: f = 6'h00;
        endcase
        return f;
    endfunction

    // ==========================================
    // apb decode
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign mapped = rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_SMC)
        || rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_RSS)
        || rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_STAT)
        || rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_CLR)
        || rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_EN);
    // ready only once read data was loaded, so a stalled setup edge costs a wait state
    assign pready_o = access && ce_i && rd_armed;
    assign pslverr_o = pready_o && !mapped;
    assign wr_smc = pready_o && pwrite_i && rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_SMC);
    assign wr_rss = pready_o && pwrite_i && rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_RSS);
    assign wr_en = pready_o && pwrite_i && rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_EN);
    assign wr_clr = pready_o && pwrite_i && rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_CLR);
    assign sw_hit = wr_rss && pwdata_i[rsl_pkg::RSS_SW_BIT];

    // ==========================================
    // configuration and read data
    always_comb
    begin
        next_mon_en = mon_en;
        next_sup_sel = sup_sel;
        next_loss_en = loss_en;
        next_cmp_sel = cmp_sel;
        next_prdata = prdata_o;
        next_rd_armed = psel_i && !(access && rd_armed);
        if (state == rsl_pkg::ST_POR)
        begin
            next_mon_en = rsl_pkg::MON_EN_RST;
        end
        else if (wr_smc)
        begin
            next_mon_en = pwdata_i[rsl_pkg::SMC_EN_BIT];
        end
        if (wr_rss)
        begin
            next_sup_sel = pwdata_i[rsl_pkg::RSS_POR_BIT];
            next_loss_en = pwdata_i[rsl_pkg::RSS_LOSS_BIT];
            next_cmp_sel = pwdata_i[rsl_pkg::RSS_CMP_BIT];
        end
        if (psel_i && !rd_armed)
        begin
            next_prdata = 32'h00000000;
            if (rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_SMC))
            begin
                next_prdata[rsl_pkg::SMC_EN_BIT] = mon_en;
                next_prdata[rsl_pkg::SMC_STAT_BIT] = supply_ok_i;
            end
            else if (rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_RSS))
            begin
                next_prdata[5:0] = rss_flags;
            end
            else if (rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_STAT))
            begin
                next_prdata[rsl_pkg::IRQ_W-1:0] = irq_stat;
            end
            else if (rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_IRQ_EN))
            begin
                next_prdata[rsl_pkg::IRQ_W-1:0] = irq_en;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mon_en <= rsl_pkg::MON_EN_RST;
            sup_sel <= rsl_pkg::SEL_RST;
            loss_en <= rsl_pkg::SEL_RST;
            cmp_sel <= rsl_pkg::SEL_RST;
            prdata_o <= 32'h00000000;
            rd_armed <= 1'b0;
        end
        else if (ce_i)
        begin
            mon_en <= next_mon_en;
            sup_sel <= next_sup_sel;
            loss_en <= next_loss_en;
            cmp_sel <= next_cmp_sel;
            prdata_o <= next_prdata;
            rd_armed <= next_rd_armed;
        end
    end

    // ==========================================
    // clock loss detector
    rsl_clock_loss u_loss (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .enable_i(loss_en),
        .mon_clk_i(mon_clk_i),
        .timeout_o(loss_pulse)
    );

    // ==========================================
    // reset sequencer
    always_comb
    begin
        hit_cause = rsl_pkg::CAUSE_NONE;
        if (mon_en && sup_sel && !supply_ok_i)
        begin
            hit_cause = rsl_pkg::CAUSE_SUPPLY;
        end
        else if (!pin_rst_b_i && !rst_pin_oe_o) // own pull-down reads back low
        begin
            hit_cause = rsl_pkg::CAUSE_PIN;
        end
        else if (loss_pulse)
        begin
            hit_cause = rsl_pkg::CAUSE_LOSS;
        end
        else if (cmp_sel && !cmp_out_i)
        begin
            hit_cause = rsl_pkg::CAUSE_CMP;
        end
        else if (sw_hit)
        begin
            hit_cause = rsl_pkg::CAUSE_SW;
        end
    end

    always_comb
    begin
        next_state = state;
        next_cause = cause;
        next_cnt = cnt;
        next_rss_flags = rss_flags;
        unique case (state)
            rsl_pkg::ST_POR:
            begin
                if (cnt == rsl_pkg::rsl_cnt_t'(POR_DELAY_CYC - 1))
                begin
                    next_state = rsl_pkg::ST_RUN;
                    next_cnt = '0;
                    next_rss_flags = flag_word(rsl_pkg::CAUSE_SUPPLY);
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
            rsl_pkg::ST_RUN:
            begin
                if (hit_cause != rsl_pkg::CAUSE_NONE)
                begin
                    next_state = rsl_pkg::ST_HOLD;
                    next_cause = hit_cause;
                end
            end
            rsl_pkg::ST_HOLD:
            begin
                if (hit_cause != rsl_pkg::CAUSE_NONE)
                begin
                    if (hit_cause < cause)
                    begin
                        next_cause = hit_cause;
                    end
                end
                else
                begin
                    next_state = rsl_pkg::ST_RUN;
                    next_rss_flags = flag_word(cause);
                end
            end
            default:
            begin
                next_state = rsl_pkg::ST_POR;
            end
        endcase
        next_sys_rst_b = (next_state == rsl_pkg::ST_RUN);
        next_pin_oe = (next_state == rsl_pkg::ST_POR)
            || ((next_state == rsl_pkg::ST_HOLD)
            && (next_cause == rsl_pkg::CAUSE_SUPPLY));
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= rsl_pkg::ST_POR;
            cause <= rsl_pkg::CAUSE_NONE;
            cnt <= '0;
            rss_flags <= rsl_pkg::RSS_FLAGS_RST;
            sys_rst_b_o <= 1'b0;
            rst_pin_oe_o <= 1'b1;
        end
        else if (ce_i)
        begin
            state <= next_state;
            cause <= next_cause;
            cnt <= next_cnt;
            rss_flags <= next_rss_flags;
            sys_rst_b_o <= next_sys_rst_b;
            rst_pin_oe_o <= next_pin_oe;
        end
    end

    // open drain pin only ever pulls low
    assign rst_pin_o = 1'b0;

    // ==========================================
    // interrupt status
    assign irq_ev = {loss_pulse, cmp_prev && !cmp_out_i, sup_prev && !supply_ok_i};
    assign irq_clr = wr_clr ? pwdata_i[rsl_pkg::IRQ_W-1:0] : rsl_pkg::IRQ_RST;

    always_comb
    begin
        next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
        next_irq_en = wr_en ? pwdata_i[rsl_pkg::IRQ_W-1:0] : irq_en;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_stat <= rsl_pkg::IRQ_RST;
            irq_en <= rsl_pkg::IRQ_RST;
            sup_prev <= 1'b0;
            cmp_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            sup_prev <= supply_ok_i;
            cmp_prev <= cmp_out_i;
        end
    end

    assign irq_o = |(irq_stat & irq_en);

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_sup_end;
        ce_i && state == rsl_pkg::ST_HOLD && cause == rsl_pkg::CAUSE_SUPPLY
            && hit_cause == rsl_pkg::CAUSE_NONE;
    endsequence

    sequence s_sw_write;
        ce_i && state == rsl_pkg::ST_RUN && hit_cause == rsl_pkg::CAUSE_SW;
    endsequence

    supply_hold_a: assert property (ce_i && state == rsl_pkg::ST_RUN && mon_en && sup_sel
        && !supply_ok_i |=> !sys_rst_b_o && rst_pin_oe_o)
        else $error("supply low did not reset and pull pin");
    supply_nodelay_a: assert property (s_sup_end |=> sys_rst_b_o
        && rss_flags[rsl_pkg::RSS_POR_BIT])
        else $error("supply reset release delayed or flag wrong");
    por_mon_off_a: assert property (state == rsl_pkg::ST_POR && ce_i |=> !mon_en)
        else $error("monitor enable survived power-on reset");
    status_live_a: assert property (ce_i && setup
        && rsl_pkg::word_hit(paddr_i, rsl_pkg::IDX_SMC)
        |=> prdata_o[rsl_pkg::SMC_STAT_BIT] == $past(supply_ok_i))
        else $error("supply status bit not live");
    pin_reset_a: assert property (ce_i && state == rsl_pkg::ST_RUN && !pin_rst_b_i
        |=> !sys_rst_b_o)
        else $error("pin low did not reset");
    pin_quiet_a: assert property (state == rsl_pkg::ST_HOLD
        && (cause == rsl_pkg::CAUSE_LOSS || cause == rsl_pkg::CAUSE_CMP) |-> !rst_pin_oe_o)
        else $error("reset pin driven by clock loss or comparator");
    cmp_reset_a: assert property (ce_i && state == rsl_pkg::ST_RUN && cmp_sel
        && !cmp_out_i |=> !sys_rst_b_o)
        else $error("comparator low did not reset");
    sw_reset_a: assert property (s_sw_write |=> !sys_rst_b_o
        && cause == rsl_pkg::CAUSE_SW)
        else $error("software reset not taken");
    exit_flags_a: assert property (ce_i && state == rsl_pkg::ST_HOLD
        && hit_cause == rsl_pkg::CAUSE_NONE |=> rss_flags == flag_word($past(cause)))
        else $error("reset flags wrong after release");
    irq_set_a: assert property (ce_i && |irq_ev
        |=> (irq_stat & $past(irq_ev)) == $past(irq_ev))
        else $error("interrupt event lost");

endmodule

// [test/rsl_far_side_model.sv]
// far side model: reset pin with pull-up, monitor outputs and watched clock
`timescale 1ns/1ps
module rsl_far_side_model (
    input wire logic sys_clk_i,
    input wire logic rst_pin_oe_i,
    input wire logic pull_b_i,
    input wire logic supply_req_i,
    input wire logic cmp_req_i,
    input wire logic clk_run_i,
    output logic pin_rst_b_o,
    output logic supply_ok_o,
    output logic cmp_out_o,
    output logic mon_clk_o
);
    logic [1:0] div;
    // ==========================================
    // open-drain pin, pulled up unless someone pulls it low
    assign pin_rst_b_o = ~(rst_pin_oe_i | ~pull_b_i);
    initial
    begin
        div = 2'h0;
        supply_ok_o = 1'h1;
        cmp_out_o = 1'h1;
        mon_clk_o = 1'h0;
    end
    // ==========================================
    // analog outputs and watched clock, the clock stands still when stopped
    always @(posedge sys_clk_i)
    begin
        supply_ok_o <= supply_req_i;
        cmp_out_o <= cmp_req_i;
        if (clk_run_i)
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
            begin
                mon_clk_o <= ~mon_clk_o;
            end
        end
    end
endmodule

// [test/rsl_reset_source_logic_tb.sv]
// self-checking bench of the reset source logic
`timescale 1ns/1ps
module rsl_reset_source_logic_tb;
    localparam int POR = 32;
    localparam int LOSS = rsl_pkg::LOSS_CYC;
    logic sys_clk_i = 1'h0, rst_b_i = 1'h0, ce_i = 1'h1;
    logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, v, rd;
    logic pready_o, pslverr_o, supply_ok_i, pin_rst_b_i, cmp_out_i, mon_clk_i, err;
    logic sys_rst_b_o, rst_pin_oe_o, irq_o;
    logic pull_b = 1'h1, sreq = 1'h1, creq = 1'h1, crun = 1'h1;
    logic m_en;
    logic [7:0] m_flags;
    logic [2:0] m_ien, m_ist;
    int fail_count = 0, tests_run = 0, seed = 62, n;

    rsl_reset_source_logic #(.POR_DELAY_CYC(POR)) rsl_reset_source_logic_inst (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .supply_ok_i(supply_ok_i), .pin_rst_b_i(pin_rst_b_i),
        .cmp_out_i(cmp_out_i), .mon_clk_i(mon_clk_i), .sys_rst_b_o(sys_rst_b_o),
        .rst_pin_o(), .rst_pin_oe_o(rst_pin_oe_o), .irq_o(irq_o));
    rsl_far_side_model rsl_far_side_model_inst (
        .sys_clk_i(sys_clk_i), .rst_pin_oe_i(rst_pin_oe_o), .pull_b_i(pull_b),
        .supply_req_i(sreq), .cmp_req_i(creq), .clk_run_i(crun),
        .pin_rst_b_o(pin_rst_b_i), .supply_ok_o(supply_ok_i), .cmp_out_o(cmp_out_i),
        .mon_clk_o(mon_clk_i));

    initial
    begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================
    // model of the register contents
    function automatic logic [31:0] exp_reg(input logic [9:0] idx);
        case (idx)
            rsl_pkg::IDX_SMC: return {24'h0, m_en, supply_ok_i, 6'h0};
            rsl_pkg::IDX_RSS: return {24'h0, m_flags};
            rsl_pkg::IDX_IRQ_STAT: return {29'h0, m_ist};
            rsl_pkg::IDX_IRQ_EN: return {29'h0, m_ien};
            default: return 32'h0;
        endcase
    endfunction
    // ==========================================
    // compares and bus tasks
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp, input string s);
        chk_reg({31'h0, got}, {31'h0, exp}, s);
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
        output logic [31:0] d, output logic e);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= {idx, 2'h0};
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'h1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'h1 && k < 50)
        begin
            @(posedge sys_clk_i);
            k++;
        end
        d = prdata_o;
        e = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        chk_pin(k < 50, 1'h1, "pready wait");
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'h1, idx, wd, d, e);
    endtask
    task automatic rd_chk(input logic [9:0] idx);
        logic [31:0] d;
        logic e;
        apb(1'h0, idx, 32'h0, d, e);
        chk_reg(d, exp_reg(idx), "register read");
    endtask
    task automatic wait_rst(input logic lvl, input int max);
        n = 0;
        while (sys_rst_b_o !== lvl && n < max)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_pin(sys_rst_b_o, lvl, "system reset level");
    endtask
    task automatic hold(input logic oe);
        repeat (4)
        begin
            @(negedge sys_clk_i);
            chk_pin(sys_rst_b_o, 1'h0, "held in reset");
            chk_pin(rst_pin_oe_o, oe, "pin drive");
        end
        @(posedge sys_clk_i);
    endtask
    task automatic finish_test;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial
    begin
        #1000000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    // ==========================================
    // scenarios
    initial
    begin
        m_en = 1'h0;
        m_flags = 8'h02;
        m_ien = 3'h0;
        m_ist = 3'h0;
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'h1;
        wait_rst(1'h1, POR + 4);
        chk_pin(n >= POR - 1, 1'h1, "power-on delay");
        rd_chk(rsl_pkg::IDX_RSS);
        rd_chk(rsl_pkg::IDX_SMC);
        apb(1'h0, 10'h000, 32'h0, rd, err);
        chk_pin(err, 1'h1, "unmapped error");
        chk_reg(rd, 32'h0, "unmapped data");
        repeat (4)
        begin
            v = $random(seed);
            wr(rsl_pkg::IDX_IRQ_EN, v);
            m_ien = v[2:0];
            rd_chk(rsl_pkg::IDX_IRQ_EN);
        end
        $display("test power-on done");
        wr(rsl_pkg::IDX_IRQ_EN, 32'h0);
        wr(rsl_pkg::IDX_IRQ_CLR, 32'h7);
        m_ien = 3'h0;
        sreq <= 1'h0;
        repeat (3) @(negedge sys_clk_i);
        m_ist = 3'h1;
        rd_chk(rsl_pkg::IDX_SMC);
        rd_chk(rsl_pkg::IDX_IRQ_STAT);
        chk_pin(irq_o, 1'h0, "masked irq");
        chk_pin(sys_rst_b_o, 1'h1, "supply not a source");
        wr(rsl_pkg::IDX_IRQ_EN, 32'h1);
        @(negedge sys_clk_i);
        chk_pin(irq_o, 1'h1, "irq raised");
        wr(rsl_pkg::IDX_IRQ_CLR, 32'h1);
        @(negedge sys_clk_i);
        chk_pin(irq_o, 1'h0, "irq cleared");
        @(posedge sys_clk_i);
        sreq <= 1'h1;
        $display("test status and irq done");
        wr(rsl_pkg::IDX_SMC, 32'h80);
        m_en = 1'h1;
        repeat (20) @(posedge sys_clk_i);
        wr(rsl_pkg::IDX_RSS, 32'h02);
        sreq <= 1'h0;
        wait_rst(1'h0, 4);
        hold(1'h1);
        chk_pin(pin_rst_b_i, 1'h0, "pin pulled low");
        sreq <= 1'h1;
        wait_rst(1'h1, 6);
        rd_chk(rsl_pkg::IDX_RSS);
        $display("test supply reset done");
        wr(rsl_pkg::IDX_RSS, 32'h12);
        wait_rst(1'h0, 3);
        wait_rst(1'h1, 3);
        m_flags = 8'h10;
        rd_chk(rsl_pkg::IDX_RSS);
        rd_chk(rsl_pkg::IDX_SMC);
        $display("test software reset done");
        pull_b <= 1'h0;
        wait_rst(1'h0, 4);
        hold(1'h0);
        pull_b <= 1'h1;
        wait_rst(1'h1, 4);
        m_flags = 8'h01;
        rd_chk(rsl_pkg::IDX_RSS);
        $display("test pin reset done");
        wr(rsl_pkg::IDX_RSS, 32'h20);
        creq <= 1'h0;
        wait_rst(1'h0, 4);
        hold(1'h0);
        chk_pin(pin_rst_b_i, 1'h1, "pin left alone");
        creq <= 1'h1;
        wait_rst(1'h1, 4);
        m_flags = 8'h20;
        rd_chk(rsl_pkg::IDX_RSS);
        $display("test comparator reset done");
        wr(rsl_pkg::IDX_RSS, 32'h04);
        crun <= 1'h0;
        wait_rst(1'h0, LOSS + 20);
        chk_pin(n >= LOSS - 4, 1'h1, "loss time");
        chk_pin(rst_pin_oe_o, 1'h0, "pin not driven");
        @(posedge sys_clk_i);
        crun <= 1'h1;
        wait_rst(1'h1, 3);
        m_flags = 8'h04;
        rd_chk(rsl_pkg::IDX_RSS);
        wr(rsl_pkg::IDX_RSS, 32'h00);
        crun <= 1'h0;
        n = 0;
        repeat (LOSS + 50)
        begin
            @(negedge sys_clk_i);
            n += (sys_rst_b_o !== 1'h1);
        end
        chk_pin(n == 0, 1'h1, "detector off");
        rd_chk(rsl_pkg::IDX_RSS);
        $display("test clock loss done");
        @(posedge sys_clk_i);
        rst_b_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'h1;
        @(negedge sys_clk_i);
        chk_pin(rst_pin_oe_o, 1'h1, "pin driven in power-on");
        wr(rsl_pkg::IDX_SMC, 32'h80);
        wait_rst(1'h1, POR + 4);
        chk_pin(n >= POR - 3, 1'h1, "second power-on delay");
        m_en = 1'h0;
        m_flags = 8'h02;
        rd_chk(rsl_pkg::IDX_SMC);
        ce_i <= 1'h0;
        fork
            rd_chk(rsl_pkg::IDX_RSS);
            begin
                repeat (3) @(posedge sys_clk_i);
                ce_i <= 1'h1;
            end
        join
        $display("test second power-on done");
        finish_test();
    end
endmodule
